/* design/hfc_fifo_config_regs.sv */
// apb register bank that configures the fifo array organisation and data flow
// Behaviour
// - first-fifo used only in sequence flow
// - first-fifo bit0 direction, 0 tx, 1 rx
// - first-fifo bits 4..1 number, 7..5 reserved
// - low nibble: shared tx threshold, 16-byte steps
// - high nibble: shared rx threshold, 16-byte steps
// - bidirectional count/size codes, fourth code forbidden
// - one-direction doubles size, upper codes forbidden
// - mode bits 3..2 select data flow
// - bit4 one-direction, bit5 picks its direction
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hfc_fifo_config_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic [7:0]       txThresholdBytes,
  output logic [7:0]       rxThresholdBytes,
  output logic [4:0]       fifoCount,
  output logic [9:0]       fifoSizeBytes,
  output logic             txFifosPresent,
  output logic             rxFifosPresent,
  output logic             simpleFlow,
  output logic             channelSelectFlow,
  output logic             sequenceFlow,
  output logic [3:0]       seqFirstNum,
  output logic             seqFirstIsReceive,
  output logic             configError
);

  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [3:0]              firstNum;
    logic                    firstDir;
    logic [3:0]              thrTx;
    logic [3:0]              thrRx;
    logic [1:0]              cntSel;
    hfc_pkg::hfc_data_flow_e flow;
    logic                    oneDir;
    logic                    oneRx;
    logic [7:0]              txBytes;
    logic [7:0]              rxBytes;
    logic [4:0]              count;
    logic [9:0]              size;
    logic                    txOn;
    logic                    rxOn;
    logic [3:0]              seqNum;
    logic                    seqDir;
    logic                    badCnt;
    logic                    badFlow;
    logic                    simple;
    logic                    chan;
    logic                    seq;
    logic                    err;
  } hfc_state_s;

  hfc_state_s state_reg;
  hfc_state_s state_next;

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by both thresholds and by the address compare

  function automatic logic [7:0] thr_bytes(input logic [3:0] steps);
    thr_bytes = {steps, 4'h0};
  endfunction : thr_bytes

  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic accessDone;
  logic wrFirst;
  logic wrThr;
  logic wrMode;
  logic rdStatus;
  logic mapped;

  always_comb begin
    state_next = state_reg;
    // one wait state: pready rises in the second access cycle
    accessDone = psel && penable && state_reg.pready;
    wrFirst  = accessDone && pwrite && hit(paddr, hfc_pkg::SEQ_FIRST_IDX);
    wrThr    = accessDone && pwrite && hit(paddr, hfc_pkg::FILL_THR_IDX);
    wrMode   = accessDone && pwrite && hit(paddr, hfc_pkg::ORG_MODE_IDX);
    rdStatus = !pwrite && hit(paddr, hfc_pkg::CFG_STATUS_IDX);
    mapped   = hit(paddr, hfc_pkg::SEQ_FIRST_IDX) || hit(paddr, hfc_pkg::FILL_THR_IDX)
            || hit(paddr, hfc_pkg::ORG_MODE_IDX) || rdStatus;

    state_next.pready  = psel && penable && !state_reg.pready;
    state_next.pslverr = psel && penable && !state_reg.pready && !mapped;
    state_next.prdata  = 32'h0000_0000;
    if (psel && penable && !state_reg.pready && rdStatus) begin
      // status word: the only way software can see what the bank decoded
      state_next.prdata[0]    = state_reg.badCnt;
      state_next.prdata[1]    = state_reg.badFlow;
      state_next.prdata[2]    = state_reg.txOn;
      state_next.prdata[3]    = state_reg.rxOn;
      state_next.prdata[8:4]  = state_reg.count;
      state_next.prdata[14:9] = state_reg.size[9:4];
    end

    // reserved bits are dropped, they are not stored
    if (wrFirst) begin
      state_next.firstDir = pwdata[hfc_pkg::FIRST_DIR_POS];
      state_next.firstNum = pwdata[hfc_pkg::FIRST_NUM_MSB:hfc_pkg::FIRST_NUM_LSB];
    end
    if (wrThr) begin
      state_next.thrTx = pwdata[hfc_pkg::THR_TX_MSB:hfc_pkg::THR_TX_LSB];
      state_next.thrRx = pwdata[hfc_pkg::THR_RX_MSB:hfc_pkg::THR_RX_LSB];
    end
    if (wrMode) begin
      state_next.cntSel = pwdata[hfc_pkg::CNT_SEL_MSB:hfc_pkg::CNT_SEL_LSB];
      state_next.flow   = hfc_pkg::hfc_data_flow_e'(pwdata[hfc_pkg::FLOW_MSB:hfc_pkg::FLOW_LSB]);
      state_next.oneDir = pwdata[hfc_pkg::ONE_DIR_POS];
      state_next.oneRx  = pwdata[hfc_pkg::ONE_RX_POS];
    end

    // derived view, registered so that every output comes from a flop
    state_next.txBytes = thr_bytes(state_next.thrTx);
    state_next.rxBytes = thr_bytes(state_next.thrRx);

    case (state_next.cntSel)
      2'b00:   state_next.count = hfc_pkg::FIFO_CNT_16;
      2'b01:   state_next.count = hfc_pkg::FIFO_CNT_8;
      2'b10:   state_next.count = hfc_pkg::FIFO_CNT_4;
      default: state_next.count = 5'h00;
    endcase
    case (state_next.cntSel)
      2'b00:   state_next.size = hfc_pkg::FIFO_SZ_64;
      2'b01:   state_next.size = {hfc_pkg::FIFO_SZ_64[8:0], 1'b0};
      2'b10:   state_next.size = {hfc_pkg::FIFO_SZ_64[7:0], 2'b00};
      default: state_next.size = 10'h000;
    endcase
    state_next.badCnt = (state_next.cntSel == 2'b11);
    if (state_next.oneDir) begin
      state_next.size   = {state_next.size[8:0], 1'b0};
      state_next.badCnt = state_next.cntSel[1];
    end
    if (state_next.badCnt) begin
      // forbidden organisation: expose no usable fifos
      state_next.count = 5'h00;
      state_next.size  = 10'h000;
    end

    // bit five only matters with one-direction set
    state_next.txOn = !state_next.oneDir || !state_next.oneRx;
    state_next.rxOn = !state_next.oneDir || state_next.oneRx;

    state_next.badFlow = (state_next.flow == hfc_pkg::HFC_BAD_FLOW);

    // flow decode kept in flops so the outputs carry no decode glitches
    state_next.simple = (state_next.flow == hfc_pkg::HFC_SIMPLE_FLOW);
    state_next.chan   = (state_next.flow == hfc_pkg::HFC_CHANNEL_FLOW);
    state_next.seq    = (state_next.flow == hfc_pkg::HFC_SEQUENCE_FLOW);
    state_next.err    = state_next.badCnt || state_next.badFlow;

    // first-fifo values are masked outside sequence flow
    if (state_next.flow == hfc_pkg::HFC_SEQUENCE_FLOW) begin
      state_next.seqNum = state_next.firstNum;
      state_next.seqDir = state_next.firstDir;
    end else begin
      state_next.seqNum = 4'h0;
      state_next.seqDir = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg.pready   <= 1'b0;
      state_reg.pslverr  <= 1'b0;
      state_reg.prdata   <= 32'h0000_0000;
      state_reg.oneDir   <= 1'b0;
      state_reg.oneRx    <= 1'b0;
      state_reg.seqNum   <= 4'h0;
      state_reg.seqDir   <= 1'b0;
      state_reg.badCnt   <= 1'b0;
      state_reg.badFlow  <= 1'b0;
      state_reg.simple   <= 1'b1;
      state_reg.chan     <= 1'b0;
      state_reg.seq      <= 1'b0;
      state_reg.err      <= 1'b0;
      state_reg.thrTx    <= hfc_pkg::THR_TX_RST;
      state_reg.thrRx    <= hfc_pkg::THR_RX_RST;
      state_reg.txBytes  <= {hfc_pkg::THR_TX_RST, 4'h0};
      state_reg.rxBytes  <= {hfc_pkg::THR_RX_RST, 4'h0};
      state_reg.firstNum <= hfc_pkg::FIRST_NUM_RST;
      state_reg.firstDir <= hfc_pkg::FIRST_DIR_RST;
      state_reg.cntSel   <= hfc_pkg::CNT_SEL_RST;
      state_reg.flow     <= hfc_pkg::HFC_SIMPLE_FLOW;
      state_reg.count    <= hfc_pkg::FIFO_CNT_16;
      state_reg.size     <= hfc_pkg::FIFO_SZ_64;
      state_reg.txOn     <= 1'b1;
      state_reg.rxOn     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready            = state_reg.pready;
  assign pslverr           = state_reg.pslverr;
  assign prdata            = state_reg.prdata;
  assign txThresholdBytes  = state_reg.txBytes;
  assign rxThresholdBytes  = state_reg.rxBytes;
  assign fifoCount         = state_reg.count;
  assign fifoSizeBytes     = state_reg.size;
  assign txFifosPresent    = state_reg.txOn;
  assign rxFifosPresent    = state_reg.rxOn;
  assign simpleFlow        = state_reg.simple;
  assign channelSelectFlow = state_reg.chan;
  assign sequenceFlow      = state_reg.seq;
  assign seqFirstNum       = state_reg.seqNum;
  assign seqFirstIsReceive = state_reg.seqDir;
  assign configError       = state_reg.err;

endmodule : hfc_fifo_config_regs
`default_nettype wire

/* design/hfc_pkg.sv */
// shared constants and types of the fifo configuration register bank
package hfc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] SEQ_FIRST_IDX  = 8'h0B;
  localparam logic [7:0] FILL_THR_IDX   = 8'h0C;
  localparam logic [7:0] ORG_MODE_IDX   = 8'h0D;
  localparam logic [7:0] CFG_STATUS_IDX = 8'h10;

  // sequence_first_fifo fields
  localparam int FIRST_DIR_POS = 0;
  localparam int FIRST_NUM_LSB = 1;
  localparam int FIRST_NUM_MSB = 4;

  // fifo_fill_threshold fields
  localparam int THR_TX_LSB = 0;
  localparam int THR_TX_MSB = 3;
  localparam int THR_RX_LSB = 4;
  localparam int THR_RX_MSB = 7;
  localparam int THR_STEP_SHIFT = 4;

  // fifo_organisation_mode fields
  localparam int CNT_SEL_LSB = 0;
  localparam int CNT_SEL_MSB = 1;
  localparam int FLOW_LSB    = 2;
  localparam int FLOW_MSB    = 3;
  localparam int ONE_DIR_POS = 4;
  localparam int ONE_RX_POS  = 5;

  // reset values
  localparam logic [3:0] THR_TX_RST    = 4'h1;
  localparam logic [3:0] THR_RX_RST    = 4'h1;
  localparam logic [3:0] FIRST_NUM_RST = 4'h0;
  localparam logic       FIRST_DIR_RST = 1'b0;
  localparam logic [1:0] CNT_SEL_RST   = 2'h0;

  // fifo organisation: bidirectional sizes; one-direction doubles them
  localparam logic [4:0] FIFO_CNT_16 = 5'h10;
  localparam logic [4:0] FIFO_CNT_8  = 5'h08;
  localparam logic [4:0] FIFO_CNT_4  = 5'h04;
  localparam logic [9:0] FIFO_SZ_64  = 10'h040;

  typedef enum logic [1:0] {
    HFC_SIMPLE_FLOW   = 2'b00,
    HFC_CHANNEL_FLOW  = 2'b01,
    HFC_BAD_FLOW      = 2'b10,
    HFC_SEQUENCE_FLOW = 2'b11
  } hfc_data_flow_e;

endpackage : hfc_pkg

/* sim/hfc_cfg_chk.sv */
// assertions on the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module hfc_cfg_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  txThresholdBytes,
  input wire logic [7:0]  rxThresholdBytes,
  input wire logic [4:0]  fifoCount,
  input wire logic [9:0]  fifoSizeBytes,
  input wire logic        configError,
  input wire logic        sequenceFlow,
  input wire logic [3:0]  seqFirstNum
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire wrOk = pready && pwrite && !pslverr;
  one_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  wo_read_a: assert property (pready && !pwrite && paddr inside {10'h02C, 10'h030, 10'h034} |-> prdata == 32'h0)
    else $error("config read not zero");
  unmapped_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned not refused");
  tx_thr_a: assert property (wrOk && paddr == 10'h030 |=> txThresholdBytes == {$past(pwdata[3:0]), 4'h0})
    else $error("tx threshold wrong");
  rx_thr_a: assert property (wrOk && paddr == 10'h030 |=> rxThresholdBytes == {$past(pwdata[7:4]), 4'h0})
    else $error("rx threshold wrong");
  seq_off_a: assert property (!sequenceFlow |-> seqFirstNum == 4'h0)
    else $error("first fifo used outside sequence");
  fifo_ram_a: assert property (!configError |-> fifoCount * fifoSizeBytes inside {32'd1024, 32'd2048})
    else $error("fifo ram split wrong");
endmodule : hfc_cfg_chk
bind hfc_fifo_config_regs hfc_cfg_chk chk_u (.*);
`default_nettype wire

/* sim/hfc_host_model.sv */
// host model: apb master programming the configuration bank
`timescale 1ns/1ps
`default_nettype none
module hfc_host_model (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [9:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  logic hung = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // subchannel setup and fifo enables live elsewhere; none touched here
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hung = hung || n == 50;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look valid
    pwdata <= ~d;
  endtask : xfer
endmodule : hfc_host_model
`default_nettype wire

/* sim/hfc_fifo_config_regs_tb.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hfc_fifo_config_regs_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, txFifosPresent, rxFifosPresent, err;
  logic simpleFlow, channelSelectFlow, sequenceFlow, seqFirstIsReceive, configError;
  logic [9:0] paddr, fifoSizeBytes;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] txThresholdBytes, rxThresholdBytes;
  logic [4:0] fifoCount;
  logic [3:0] seqFirstNum;
  int mismatches = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  hfc_fifo_config_regs dut_u (.*);
  hfc_host_model host_u (.*);
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // outputs are judged mid-cycle, after the taking edge has landed
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    host_u.xfer(w, a, {24'h0, d}, rd, err);
    @(negedge ref_clk);
    if (host_u.hung) begin
      mismatches++;
      give_verdict();
    end
  endtask : acc
  task automatic thresholds;
    check("reset", {txThresholdBytes, rxThresholdBytes, fifoCount, simpleFlow}, {8'h10, 8'h10, 5'h10, 1'b1});
    acc(1'b0, 10'h040, 8'h00);
    check("status", {rd[31:1], err}, 32'h0000_090C);
    acc(1'b1, 10'h040, 8'hFF);
    check("stwrite", {31'h0, err}, 32'h0000_0001);
    acc(1'b1, 10'h030, 8'h0F);
    check("thr", {txThresholdBytes, rxThresholdBytes}, 32'hF000);
    acc(1'b1, 10'h030, 8'hF0);
    check("thr", {txThresholdBytes, rxThresholdBytes}, 32'h00F0);
    acc(1'b0, 10'h030, 8'h00);
    check("rdback", rd ^ {31'h0, err}, 32'h0);
    acc(1'b1, 10'h031, 8'hFF);
    check("unmapped", {err, txThresholdBytes}, 32'h100);
  endtask : thresholds
  task automatic modes;
    logic [1:0] c, f;
    logic u, r, bad;
    for (int i = 0; i < 64; i++) begin
      {r, u, f, c} = i[5:0];
      bad = c == 2'h3 || (u && c[1]);
      acc(1'b1, 10'h034, i[7:0]);
      check("org", {fifoCount, fifoSizeBytes}, bad ? 32'h0 : {5'h10 >> c, 10'h040 << (c + u)});
      check("dir", {txFifosPresent, rxFifosPresent}, {!u || !r, !u || r});
      check("flow", {simpleFlow, channelSelectFlow, sequenceFlow, configError}, {f == 0, f == 1, f == 3, bad | f == 2});
    end
  endtask : modes
  task automatic first_fifo;
    acc(1'b1, 10'h034, 8'h00);
    acc(1'b1, 10'h02C, 8'hFF);
    check("first", {seqFirstNum, seqFirstIsReceive}, 32'h0);
    acc(1'b1, 10'h034, 8'h0C);
    check("first", {seqFirstNum, seqFirstIsReceive}, 32'h1F);
    acc(1'b1, 10'h02C, 8'hF4);
    check("first", {seqFirstNum, seqFirstIsReceive}, 32'h14);
  endtask : first_fifo
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    thresholds();
    modes();
    first_fifo();
    give_verdict();
  end
endmodule : hfc_fifo_config_regs_tb
`default_nettype wire
